// >>> hw/sme_serial.sv
// Three-wire serial engine: shifts one command frame out and, for read and reload, one byte back in.
// Assumes 16-bit words are never used; frames are start bit, opcode, address, then a data byte for read, reload, write and fill only.
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
`include "sme_regs.svh"
module sme_serial #(
  parameter int unsigned TIMEOUT_CYC = `SME_TIMEOUT_MS * 1000 * `SME_CLK_MHZ
) (
  // Clock and reset
  input  wire logic            mclk_i,
  input  wire logic            reset_i,
  // Request and answer
  input  wire sme_pkg::sme_req_t req_i,
  output sme_pkg::sme_rsp_t    rsp_o,
  // Serial pins
  output logic                 cs_o,
  output logic                 sck_o,
  output logic                 sdo_o,
  input  wire logic            sdi_sync_i
);
  typedef enum logic [3:0] {
    SS_IDLE = 4'b0001,
    SS_SHIFT = 4'b0010,
    SS_POLL = 4'b0100,
    SS_DONE = 4'b1000
  } sme_ser_state_t;

  sme_ser_state_t state;
  logic [29:0] shreg;
  logic [5:0]  bits_left;
  logic [7:0]  div;
  logic [7:0]  rx;
  logic [31:0] tmo;
  logic        reading;
  logic        tick;
  logic        is_prog;
  logic        is_read;

  function automatic logic [1:0] opc_bits(input sme_pkg::sme_opcode_t op);
    unique case (op)
      sme_pkg::SME_OP_READ,
      sme_pkg::SME_OP_RELOAD: opc_bits = 2'h2;
      sme_pkg::SME_OP_WRITE,
      sme_pkg::SME_OP_FILL:   opc_bits = (op == sme_pkg::SME_OP_WRITE) ? 2'h1 : 2'h0;
      sme_pkg::SME_OP_ERASE:  opc_bits = 2'h3;
      default:                opc_bits = 2'h0;
    endcase
  endfunction

  // Extended opcodes put their selector into the top address bits
  function automatic logic [8:0] addr_bits(input sme_pkg::sme_opcode_t op, input logic [8:0] a);
    unique case (op)
      sme_pkg::SME_OP_LOCK:   addr_bits = 9'h000;
      sme_pkg::SME_OP_UNLOCK: addr_bits = 9'h180;
      sme_pkg::SME_OP_FILL:   addr_bits = 9'h080;
      sme_pkg::SME_OP_BULK:   addr_bits = 9'h100;
      sme_pkg::SME_OP_RELOAD: addr_bits = 9'h000; // Signature lives in the first byte
      default:                addr_bits = a;
    endcase
  endfunction

  assign tick    = (div == `SME_SCLK_HALF);
  assign is_prog = (req_i.opcode == sme_pkg::SME_OP_WRITE) || (req_i.opcode == sme_pkg::SME_OP_FILL) ||
                   (req_i.opcode == sme_pkg::SME_OP_ERASE) || (req_i.opcode == sme_pkg::SME_OP_BULK);
  assign is_read = (req_i.opcode == sme_pkg::SME_OP_READ) || (req_i.opcode == sme_pkg::SME_OP_RELOAD);

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state     <= SS_IDLE;
      shreg     <= 30'h0;
      bits_left <= 6'h0;
      div       <= 8'h0;
      rx        <= 8'h0;
      tmo       <= 32'h0;
      reading   <= 1'b0;
      cs_o      <= 1'b0;
      sck_o     <= 1'b0;
      sdo_o     <= 1'b0;
      rsp_o     <= '0;
    end else begin
      rsp_o.done <= 1'b0;
      div        <= tick ? 8'h0 : div + 8'h1;
      unique case (state)
        SS_IDLE: begin
          if (req_i.start) begin
            // Start bit goes out now so it is settled before the first rising clock
            sdo_o     <= `SME_START_BIT;
            shreg     <= {opc_bits(req_i.opcode),
                          addr_bits(req_i.opcode, req_i.location), req_i.wdata, 11'h0};
            bits_left <= `SME_FRAME_BITS + ((is_read || req_i.opcode == sme_pkg::SME_OP_WRITE ||
                         req_i.opcode == sme_pkg::SME_OP_FILL) ? `SME_BYTE_BITS : 6'd0);
            reading   <= is_read;
            rx        <= 8'h0;
            cs_o      <= 1'b1;
            div       <= 8'h0;
            state     <= SS_SHIFT;
          end
        end
        // Data out changes on the falling clock, so the memory samples a settled line
        SS_SHIFT: if (tick) begin
          sck_o <= ~sck_o;
          if (!sck_o) begin
            bits_left <= bits_left - 6'h1;
            if (reading && bits_left <= `SME_BYTE_BITS)
              rx <= {rx[6:0], sdi_sync_i};
          end else if (bits_left == 6'h0) begin
            cs_o  <= 1'b0;
            sdo_o <= 1'b0;
            tmo   <= 32'h0;
            state <= is_prog ? SS_POLL : SS_DONE;
          end else begin
            sdo_o <= shreg[29];
            shreg <= {shreg[28:0], 1'b0};
          end
        end
        SS_POLL: begin
          // Ready is the line going high after chip select returns; the first few
          // samples still show the released line through the synchroniser
          cs_o <= 1'b1;
          tmo  <= tmo + 32'h1;
          if (sdi_sync_i && tmo >= `SME_POLL_SETTLE) begin
            cs_o  <= 1'b0;
            state <= SS_DONE;
          end else if (tmo >= TIMEOUT_CYC - 1) begin
            cs_o            <= 1'b0;
            rsp_o.timed_out <= 1'b1;
            state           <= SS_DONE;
          end
        end
        SS_DONE: begin
          sck_o       <= 1'b0;
          rsp_o.rdata <= rx;
          rsp_o.done  <= 1'b1;
          rsp_o.loaded <= (req_i.opcode == sme_pkg::SME_OP_RELOAD) && (rx == `SME_SIGNATURE);
          state       <= SS_IDLE;
        end
        default: state <= SS_IDLE;
      endcase
      if (state == SS_IDLE)
        rsp_o.timed_out <= 1'b0;
    end
  end
endmodule

// >>> hw/sme_regs.svh
// Register offsets, field positions and timing constants of the serial memory controller.
// Assumes inclusion by bare name from design files.
`ifndef SME_REGS_SVH
`define SME_REGS_SVH
`define SME_CMD_OFFSET    12'h040
`define SME_DATA_OFFSET   12'h044
`define SME_BUSY_BIT      31
`define SME_OPC_HI        30
`define SME_OPC_LO        28
`define SME_TO_BIT        10
`define SME_DL_BIT        9
`define SME_ADDR_HI       8
`define SME_ADDR_LO       0
`define SME_DATA_HI       7
`define SME_SIGNATURE     8'ha5
`define SME_TIMEOUT_MS    30
`define SME_CLK_MHZ       100
`define SME_SCLK_HALF     8'h04
`define SME_START_BIT     1'b1
`define SME_FRAME_BITS    6'd12
`define SME_BYTE_BITS     6'd8
`define SME_POLL_SETTLE   32'h4
`endif

// >>> hw/sme_pkg.sv
// Types shared by the serial memory controller files.
// Assumes nothing beyond a SystemVerilog compiler.
package sme_pkg;
  typedef enum logic [2:0] {
    SME_OP_READ   = 3'h0,
    SME_OP_LOCK   = 3'h1,
    SME_OP_UNLOCK = 3'h2,
    SME_OP_WRITE  = 3'h3,
    SME_OP_FILL   = 3'h4,
    SME_OP_ERASE  = 3'h5,
    SME_OP_BULK   = 3'h6,
    SME_OP_RELOAD = 3'h7
  } sme_opcode_t;

  typedef struct packed {
    logic        start;
    sme_opcode_t opcode;
    logic [8:0]  location;
    logic [7:0]  wdata;
  } sme_req_t;

  typedef struct packed {
    logic       done;
    logic       timed_out;
    logic       loaded;
    logic       wr_data;
    logic [7:0] rdata;
  } sme_rsp_t;
endpackage

// >>> hw/sme_sync.sv
// Two flip-flop synchroniser for a level from outside the clock domain.
// Assumes the input may change at any time.
`timescale 1ns/10ps
module sme_sync (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic reset_i,
  // Level
  input  wire logic async_i,
  output logic      sync_o
);
  logic stage1;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      stage1 <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule

// >>> hw/sme_ctrl.sv
// Notes on behaviour
// - Writing busy one starts selected operation
// - Busy holds during operation, read data valid
// - Missing device write: busy until time-out
// - Opcode bits 30:28 decode eight commands
// - Read fetches byte into data register
// - Lock command blocks erase and write
// - Unlock permits erase and write
// - Write stores data byte at address
// - Fill-all writes data to every location
// - Erase clears the addressed location
// - Bulk erase clears the whole array
// - Reload fails unless first byte signature
// - Failed reload leaves state unchanged
// - Data-in high: no time-out, clear busy
// - Data-in low: only programming commands time out
// - Loaded flag set after successful load
// - Address field is bits 8:0
// - Data register carries byte in 7:0
//
// Top of the serial memory controller: APB register slave plus the serial engine.
// Assumes an APB master on mclk_i and an external three-wire memory on the pins.
`timescale 1ns/10ps
`include "sme_regs.svh"
module sme_ctrl #(
  parameter int unsigned TIMEOUT_CYC = `SME_TIMEOUT_MS * 1000 * `SME_CLK_MHZ
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Serial memory pins
  output logic             mem_cs_o,
  output logic             mem_sck_o,
  output logic             mem_sdo_o,
  input  wire logic        serial_data_in_i
);
  sme_pkg::sme_req_t req;
  sme_pkg::sme_rsp_t rsp;
  logic              sdi_sync;
  logic              operation_busy;
  sme_pkg::sme_opcode_t operation_opcode;
  logic [8:0]        byte_location;
  logic              no_response_flag;
  logic              config_loaded_flag;
  logic [7:0]        eeprom_byte_register;
  logic              start_pulse;

  wire apb_wr      = psel_i && penable_i && pwrite_i;
  wire apb_rd      = psel_i && penable_i && !pwrite_i;
  wire hit_cmd     = (paddr_i == `SME_CMD_OFFSET);
  wire hit_data    = (paddr_i == `SME_DATA_OFFSET);
  wire wr_cmd      = apb_wr && hit_cmd;
  wire wr_data     = apb_wr && hit_data;
  // Writes while busy only act on the flag clears, so an operation in flight keeps its inputs
  wire cmd_accept  = wr_cmd && !operation_busy && pwdata_i[`SME_BUSY_BIT];
  wire [31:0] cmd_word = {operation_busy, operation_opcode, 17'h0, no_response_flag,
                          config_loaded_flag, byte_location};
  wire [31:0] data_word = {24'h0, eeprom_byte_register};

  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !hit_cmd && !hit_data;
  assign prdata_o  = !apb_rd ? 32'h0 : hit_cmd ? cmd_word : hit_data ? data_word : 32'h0;

  assign req = '{start: start_pulse, opcode: operation_opcode, location: byte_location,
                 wdata: eeprom_byte_register};

  sme_sync u_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .async_i (serial_data_in_i),
    .sync_o  (sdi_sync)
  );

  sme_serial #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_serial (
    .mclk_i     (mclk_i),
    .reset_i    (reset_i),
    .req_i      (req),
    .rsp_o      (rsp),
    .cs_o       (mem_cs_o),
    .sck_o      (mem_sck_o),
    .sdo_o      (mem_sdo_o),
    .sdi_sync_i (sdi_sync)
  );

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      operation_busy   <= 1'b0;
      operation_opcode <= sme_pkg::SME_OP_READ;
      byte_location    <= 9'h0;
      start_pulse      <= 1'b0;
    end else begin
      start_pulse <= cmd_accept;
      if (cmd_accept) begin
        operation_busy   <= 1'b1;
        operation_opcode <= sme_pkg::sme_opcode_t'(pwdata_i[`SME_OPC_HI:`SME_OPC_LO]);
        byte_location    <= pwdata_i[`SME_ADDR_HI:`SME_ADDR_LO];
      end else if (wr_cmd && !operation_busy) begin
        operation_opcode <= sme_pkg::sme_opcode_t'(pwdata_i[`SME_OPC_HI:`SME_OPC_LO]);
        byte_location    <= pwdata_i[`SME_ADDR_HI:`SME_ADDR_LO];
      end
      if (rsp.done)
        operation_busy <= 1'b0;
    end
  end

  // Flags: hardware set beats a software write-one clear in the same cycle
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      no_response_flag   <= 1'b0;
      config_loaded_flag <= 1'b0;
    end else begin
      if (rsp.done && rsp.timed_out)
        no_response_flag <= 1'b1;
      else if (wr_cmd && pwdata_i[`SME_TO_BIT])
        no_response_flag <= 1'b0;
      if (rsp.done && rsp.loaded)
        config_loaded_flag <= 1'b1;
      else if (wr_cmd && pwdata_i[`SME_DL_BIT])
        config_loaded_flag <= 1'b0;
    end
  end

  // A failed reload writes nothing back, leaving the data byte as it was
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      eeprom_byte_register <= 8'h0;
    end else begin
      if (wr_data && !operation_busy)
        eeprom_byte_register <= pwdata_i[`SME_DATA_HI:0];
      else if (rsp.done && operation_opcode == sme_pkg::SME_OP_READ)
        eeprom_byte_register <= rsp.rdata;
    end
  end

  // Lock, unlock, erase and bulk erase are frames only; the memory itself keeps the
  // write-enable latch, so a locked device simply ignores the erases, while unlock still sets the latch.

  a_busy_clears: assert property (@(posedge mclk_i) disable iff (reset_i)
    rsp.done |=> !operation_busy) else $error("busy did not clear after done");
  a_start_sets: assert property (@(posedge mclk_i) disable iff (reset_i)
    cmd_accept |=> operation_busy && start_pulse) else $error("start did not set busy");
  a_read_data: assert property (@(posedge mclk_i) disable iff (reset_i)
    rsp.done && operation_opcode == sme_pkg::SME_OP_READ |=> eeprom_byte_register == $past(rsp.rdata))
    else $error("read data not captured");
  a_timeout_flag: assert property (@(posedge mclk_i) disable iff (reset_i)
    rsp.done && rsp.timed_out |=> no_response_flag) else $error("time-out flag not set");
  a_loaded_flag: assert property (@(posedge mclk_i) disable iff (reset_i)
    rsp.done && rsp.loaded |=> config_loaded_flag) else $error("loaded flag not set");
  a_reload_keeps: assert property (@(posedge mclk_i) disable iff (reset_i)
    rsp.done && operation_opcode == sme_pkg::SME_OP_RELOAD |=> $stable(eeprom_byte_register))
    else $error("reload altered data");
  a_busy_steady: assert property (@(posedge mclk_i) disable iff (reset_i)
    operation_busy && !rsp.done |=> operation_busy) else $error("busy dropped early");
  a_lock_no_tmo: assert property (@(posedge mclk_i) disable iff (reset_i)
    rsp.done && (operation_opcode == sme_pkg::SME_OP_LOCK || operation_opcode == sme_pkg::SME_OP_READ)
    |-> !rsp.timed_out) else $error("non-programming command timed out");
endmodule

// >>> tb/sme_mem_model.sv
// Behavioural three-wire serial memory standing on the controller's pins.
// Assumes frames of start bit, 2 opcode bits, 9 address bits, optional data byte, MSB first.
`timescale 1ns/10ps
module sme_mem_model (
  // Serial pins
  input  wire logic cs_i,
  input  wire logic sck_i,
  input  wire logic sdo_i,
  output logic      sdi_o,
  // Bench controls
  input  wire logic present_i,
  input  wire logic pull_i
);
  logic [7:0]  mem [512];
  logic [19:0] sh;
  logic [8:0]  a;
  logic [1:0]  op;
  logic [7:0]  rbyte;
  logic        wen, rd_on, st, rdy;
  int          n, k;

  // Released or absent line falls to the pull level
  assign sdi_o = (present_i && cs_i && rd_on) ? rbyte[7] : (present_i && cs_i && st) ? rdy : pull_i;

  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    wen = 1'b0;  // Powers up with programming locked
    rd_on = 1'b0;
    st = 1'b0;
    rdy = 1'b0;
    n = 0;
    k = 0;
  end

  always @(posedge cs_i) begin
    n = 0;
    k = 0;
  end

  always @(posedge sck_i) if (cs_i && present_i) begin
    if (rd_on) k = k + 1;
    else begin
      sh = {sh[18:0], sdo_i};
      n = n + 1;
      if (n == 12 && sh[10:9] == 2'b10 && !st) begin
        rbyte = mem[sh[8:0]];
        rd_on = 1'b1;
      end
    end
  end

  // Data moves on the falling edge so it is settled at the sampling edge
  always @(negedge sck_i) if (rd_on && k > 0) rbyte = {rbyte[6:0], 1'b0};

  always @(posedge st) begin
    #500;
    rdy = 1'b1;
  end

  always @(negedge cs_i) begin
    rd_on = 1'b0;
    if (st) begin
      st = 1'b0;
      rdy = 1'b0;
    end else if (n >= 12 && present_i) begin
      a = (n == 20) ? sh[16:8] : sh[8:0];
      op = (n == 20) ? sh[18:17] : sh[10:9];
      case (op)
        2'b01: begin
          if (wen) mem[a] = sh[7:0];
          st = 1'b1;
        end
        2'b11: begin
          if (wen) mem[a] = 8'hff;
          st = 1'b1;
        end
        2'b00: case (a[8:7])
          2'b11: wen = 1'b1;
          2'b00: wen = 1'b0;
          2'b01: begin
            if (wen) foreach (mem[i]) mem[i] = sh[7:0];
            st = 1'b1;
          end
          default: begin
            if (wen) foreach (mem[i]) mem[i] = 8'hff;
            st = 1'b1;
          end
        endcase
        default: ;
      endcase
    end
  end
endmodule

// >>> tb/sme_ctrl_tb.sv
// Self-checking bench: APB master tasks driving command sequences against a serial memory model.
// Assumes the controller answers with zero wait states and a shortened time-out.
`timescale 1ns/10ps
module sme_ctrl_tb;
  logic        mclk_i, reset_i, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, s;
  logic        cs, sck, sdo, sdi, present, pull, e;
  int          n_fail, cmp_count;

  sme_ctrl #(.TIMEOUT_CYC(200)) sme_ctrl_i (
    .mclk_i(mclk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .mem_cs_o(cs), .mem_sck_o(sck),
    .mem_sdo_o(sdo), .serial_data_in_i(sdi));
  sme_mem_model sme_mem_model_i (
    .cs_i(cs), .sck_i(sck), .sdo_i(sdo), .sdi_o(sdi), .present_i(present), .pull_i(pull));

  always #5 mclk_i = ~mclk_i;

  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      $display("wrong value %s expected %h seen %h", nm, ex, got);
      n_fail++;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge mclk_i);
      i++;
    end while (pready !== 1'b1 && i < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      results;
    end
    @(posedge mclk_i);
  endtask

  // Starts a command and polls busy; s holds the final status word
  task automatic cmd(input logic [2:0] op, input logic [8:0] ad);
    int i;
    apb(1'b1, 12'h040, {1'b1, op, 19'h0, ad});
    apb(1'b0, 12'h040, 32'h0);
    chk("busy set", 32'h1, {31'h0, q[31]});
    i = 0;
    while (q[31] !== 1'b0 && i < 2000) begin
      apb(1'b0, 12'h040, 32'h0);
      i++;
    end
    s = q;
    if (q[31] !== 1'b0) begin
      n_fail++;
      results;
    end
  endtask

  task automatic rdbyte(input logic [8:0] ad, input logic [7:0] ex, input string nm);
    cmd(3'h0, ad);
    apb(1'b0, 12'h044, 32'h0);
    chk(nm, {24'h0, ex}, q);
  endtask

  initial begin
    mclk_i = 1'b0;
    reset_i = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    present = 1'b1;
    pull = 1'b1;
    n_fail = 0;
    cmp_count = 0;
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    apb(1'b0, 12'h040, 32'h0);
    chk("cmd reset", 32'h0, q);
    apb(1'b0, 12'h080, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    $display("test reset done");
    apb(1'b1, 12'h044, 32'h5c);
    cmd(3'h3, 9'h1a3);
    rdbyte(9'h1a3, 8'h00, "locked write");
    cmd(3'h2, 9'h0);
    apb(1'b1, 12'h044, 32'h5c);
    cmd(3'h3, 9'h1a3);
    rdbyte(9'h1a3, 8'h5c, "write read");
    apb(1'b1, 12'h044, 32'h77);
    cmd(3'h1, 9'h0);
    cmd(3'h3, 9'h1a3);
    rdbyte(9'h1a3, 8'h5c, "lock write");
    cmd(3'h2, 9'h0);
    cmd(3'h5, 9'h1a3);
    rdbyte(9'h1a3, 8'hff, "erase");
    apb(1'b1, 12'h044, 32'h3c);
    cmd(3'h4, 9'h0);
    rdbyte(9'h000, 8'h3c, "fill low");
    rdbyte(9'h1ff, 8'h3c, "fill high");
    cmd(3'h6, 9'h0);
    rdbyte(9'h1ff, 8'hff, "bulk erase");
    $display("test commands done");
    apb(1'b1, 12'h044, 32'ha5);
    cmd(3'h3, 9'h0);
    cmd(3'h7, 9'h0);
    chk("loaded set", 32'h1, {31'h0, s[9]});
    apb(1'b1, 12'h040, 32'h200);
    apb(1'b1, 12'h044, 32'h11);
    cmd(3'h3, 9'h0);
    apb(1'b1, 12'h044, 32'h22);
    cmd(3'h7, 9'h1ff);
    chk("loaded fail", 32'h0, {31'h0, s[9]});
    apb(1'b0, 12'h044, 32'h0);
    chk("data kept", 32'h22, q);
    $display("test reload done");
    present <= 1'b0;
    pull <= 1'b0;
    cmd(3'h3, 9'h005);
    chk("write timeout", 32'h1, {31'h0, s[10]});
    apb(1'b1, 12'h040, 32'h400);
    cmd(3'h0, 9'h005);
    chk("read no timeout", 32'h0, {31'h0, s[10]});
    pull <= 1'b1;
    cmd(3'h6, 9'h0);
    chk("pulled high", 32'h0, {31'h0, s[10]});
    $display("test absent done");
    results;
  end
endmodule
